// ---- bench/adc_mode_config_port_tb.sv ----
// Self-checking bench for the mode configuration port.
// Assumes the host model drives the serial pins and the bench drives clock, reset and mode.
`timescale 1ns/1ps
module adc_mode_config_port_tb;
  import amc_pkg::*;
  logic clk;
  logic reset_n;
  logic interface_select;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo_out;
  logic sdo_oe;
  logic sdo_wire;
  amc_ctrl_t ctrl;
  int n_errors;
  int n_tests;
  logic [7:0] rd;
  logic [7:0] r1;
  logic [7:0] r2;
  logic [7:0] r3;
  logic [1:0] pd_tab [3] = '{PD_NORMAL, PD_NAP, PD_SLEEP};
  logic [1:0] fmt_tab [3] = '{FMT_CMOS_FULL, FMT_LVDS_DDR, FMT_CMOS_DDR};

  amc_config_port uut (.clk(clk), .reset_n(reset_n), .interface_select(interface_select),
    .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_in(sdo_wire), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .ctrl(ctrl));
  amc_host_model host (.cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sdo_wire(sdo_wire));

  // Free running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Expected controls from the register shadows in serial mode.
  function automatic amc_ctrl_t ser_ctrl(logic [7:0] a, logic [7:0] b, logic [7:0] c);
    return {a[1:0], b[3], b[2:1], b[0], c[6:4], c[3], c[2], c[1:0]};
  endfunction : ser_ctrl

  // One write word; the shadows follow only full frames to mapped addresses.
  task automatic wr(input logic [6:0] addr, input logic [7:0] data, input int pulses);
    host.xfer({1'b0, addr, data}, pulses, rd);
    if (pulses >= 16) begin
      if (addr == ADDR_SOFT_RESET && data[SOFT_RESET_BIT]) begin
        r1 = REG_RESET_VALUE;
        r2 = REG_RESET_VALUE;
        r3 = REG_RESET_VALUE;
      end
      if (addr == ADDR_POWER_DOWN) r1 = data;
      if (addr == ADDR_CLK_TIMING) r2 = data;
      if (addr == ADDR_OUT_MODE) r3 = data;
    end
    repeat (10) @(posedge clk);
  endtask : wr

  task automatic chk_ctrl();
    check({3'h0, ctrl}, {3'h0, ser_ctrl(r1, r2, r3)});
  endtask : chk_ctrl

  // Every field code, with don't-care bits set; phase delay always pairs with stabilizer on.
  task automatic t_fields();
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_POWER_DOWN, {6'h2A, pd_tab[i % 3]}, 16);
      wr(ADDR_CLK_TIMING, {4'hA, i[2], i[1:0], (i[1:0] != 2'h0) | i[2]}, 16);
      wr(ADDR_OUT_MODE, {1'b1, i[2:0], i[0], i[1], fmt_tab[i % 3]}, 16);
      chk_ctrl();
    end
  endtask : t_fields

  // Read-back leaves registers alone and ignores the data bits sent with it.
  task automatic t_read();
    host.xfer({1'b1, ADDR_OUT_MODE, ~r3}, 16, rd);
    repeat (10) @(posedge clk);
    check({9'h0, rd[6:0]}, {9'h0, r3[6:0]});
    chk_ctrl();
    host.xfer({1'b1, ADDR_POWER_DOWN, ~r1}, 16, rd);
    repeat (10) @(posedge clk);
    check({14'h0, rd[1:0]}, {14'h0, r1[1:0]});
    host.xfer({1'b1, ADDR_SOFT_RESET, 8'hFF}, 16, rd);
    repeat (10) @(posedge clk);
    check({8'h0, rd}, 16'h0000);
    chk_ctrl();
  endtask : t_read

  // Extra clocks are ignored, short frames and unmapped writes change nothing.
  task automatic t_frames();
    wr(ADDR_POWER_DOWN, {6'h00, PD_NAP}, 20);
    chk_ctrl();
    wr(ADDR_POWER_DOWN, {6'h00, PD_SLEEP}, 12);
    chk_ctrl();
    wr(7'h05, 8'hFF, 16);
    chk_ctrl();
  endtask : t_frames

  // Soft reset needs bit 7 only; the bit clears itself so later writes stick.
  task automatic t_soft();
    wr(ADDR_SOFT_RESET, 8'h7F, 16);
    chk_ctrl();
    wr(ADDR_SOFT_RESET, 8'hA5, 16);
    check({3'h0, ctrl}, 16'h0000);
    wr(ADDR_CLK_TIMING, 8'h09, 16);
    chk_ctrl();
  endtask : t_soft

  // Straps in parallel mode, then back to the registers in serial mode.
  task automatic t_parallel();
    amc_ctrl_t exp;
    @(posedge clk) interface_select <= 1'b1;
    for (int v = 0; v < 8; v++) begin
      host.set_pins(v[2:0]);
      repeat (8) @(posedge clk);
      exp = {v[0] ? PD_SLEEP : PD_NORMAL, 3'h0, v[2], LVDS_3P5MA, 2'h0,
        v[1] ? FMT_LVDS_DDR : FMT_CMOS_FULL};
      check({3'h0, ctrl}, {3'h0, exp});
    end
    host.set_pins(3'h4);
    @(posedge clk) interface_select <= 1'b0;
    repeat (8) @(posedge clk);
    chk_ctrl();
  endtask : t_parallel

  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  // Main sequence: reset, software reset first, then the scenarios.
  initial begin
    reset_n = 1'b0;
    interface_select = 1'b0;
    n_errors = 0;
    n_tests = 0;
    r1 = 8'h00;
    r2 = 8'h00;
    r3 = 8'h00;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    check({3'h0, ctrl}, 16'h0000);
    wr(ADDR_SOFT_RESET, 8'h80, 16);
    chk_ctrl();
    t_fields();
    t_read();
    t_frames();
    t_soft();
    t_parallel();
    give_verdict();
  end
endmodule : adc_mode_config_port_tb

// ---- bench/amc_host_model.sv ----
// Host controller model: drives the serial port pins and reads back over the open drain line.
// Assumes the bench calls one task at a time; the link clock has a 125 ns period.
`timescale 1ns/1ps
module amc_host_model (
  output logic cs_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  output wire logic sdo_wire
);
  // Pull-up on the shared line, because the device can only pull it low.
  assign sdo_wire = (sdo_oe && !sdo_out) ? 1'b0 : 1'b1;

  // Idle pins: chip select high and serial clock still between frames.
  initial begin
    cs_n <= 1'b1;
    sck <= 1'b0;
    sdi <= 1'b0;
  end

  // Sends one word; pulse counts other than 16 give trailing and short frames.
  task automatic xfer(input logic [15:0] word, input int pulses, output logic [7:0] rd);
    logic last;
    rd = 8'h00;
    last = 1'b0;
    // Pins move by non-blocking assignment, so a call made on a clock edge
    // does not race the synchronisers.
    cs_n <= 1'b0;
    #62.5;
    for (int i = 0; i < pulses; i++) begin
      last = (i < 16) ? word[15 - i] : ~last;
      sdi <= last;
      #62.5;
      sck <= 1'b1;
      if (i >= 8 && i < 16) begin
        rd = {rd[6:0], sdo_wire};
      end
      #62.5;
      sck <= 1'b0;
    end
    #62.5;
    cs_n <= 1'b1;
    sdi <= ~last; // A released data line must not keep showing its last bit.
  endtask : xfer

  // Holds the three pins as static straps for parallel mode.
  task automatic set_pins(input logic [2:0] v);
    cs_n <= v[2];
    sck <= v[1];
    sdi <= v[0];
  endtask : set_pins
endmodule : amc_host_model

// ---- hdl/amc_config_port.sv ----
// Mode configuration port: parallel strap pins or a 16-bit serial write/read-back port.
// Assumes the pins are asynchronous to clk and the serial clock is far slower than clk.
`timescale 1ns/1ps

// What this block does
// - Interface select high makes the three serial pins static mode inputs.
// - Parallel mode: chip select level turns the duty stabilizer on or off.
// - Parallel mode: serial clock low gives full CMOS, high gives LVDS 3.5mA.
// - Parallel mode: data-in low is normal operation, high is sleep.
// - Interface select low makes the pins a serial register port.
// - Frame is chip select low; only the first 16 rising clocks are sampled.
// - Write command stores the data byte into the addressed register.
// - Read command shifts the register out and leaves it unchanged.
// - Data-out is open drain, pulling low only; host supplies the pull-up.
// - Writing bit 7 at address 00h clears all registers; bit self-clears.
// - Reset register is write only; unused bits are don't-care.
// - Power-down code: 00 normal, 01 nap, 11 sleep, 10 unused.
// - Timing bit 3 inverts the output clock polarity.
// - Timing bits 2-1 delay the output clock by 0, 45, 90, 135 degrees.
// - Timing bit 0 turns the duty stabilizer on.
// - Output mode bits 6-4 choose the LVDS drive current.
// - Output mode bit 3 enables termination, scaling drive current 1.6 times.
// - Output mode bit 2 puts all digital outputs into high impedance.
// - Output mode bits 1-0 choose the output format.
module amc_config_port (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic interface_select,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_in,
  output logic sdo_out,
  output logic sdo_oe,
  output amc_pkg::amc_ctrl_t ctrl
);
  import amc_pkg::*;

  logic rst_meta_q;
  logic rst_sync_q;
  logic [1:0] sel_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] sdi_sync_q;
  logic sck_prev_q;
  logic cs_prev_q;
  logic rst_n;
  logic par_mode;
  logic frame;
  logic sck_rise;
  logic sck_fall;
  logic frame_start;
  logic frame_end;
  amc_state_t state_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [7:0] pd_reg_q;
  logic [7:0] timing_reg_q;
  logic [7:0] outmode_reg_q;
  logic [7:0] read_byte_q;
  logic rd_flag_q;
  logic word_done;
  logic is_read;
  logic [6:0] word_addr;
  logic [7:0] word_data;
  logic [7:0] read_mux;
  amc_ctrl_t ctrl_d;

  // Reset is released through two flops so every flop leaves reset on the same edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // Two-flop synchronisers; only bit 1 of each pair is read by logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_sync_q <= 2'h0;
      cs_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      sdi_sync_q <= 2'h0;
    end else begin
      sel_sync_q <= {sel_sync_q[0], interface_select};
      cs_sync_q <= {cs_sync_q[0], cs_n};
      sck_sync_q <= {sck_sync_q[0], sck};
      sdi_sync_q <= {sdi_sync_q[0], sdi};
    end
  end

  // Edge history for the serial clock and chip select.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_sync_q[1];
      cs_prev_q <= cs_sync_q[1];
    end
  end

  assign par_mode = sel_sync_q[1];
  assign frame = !par_mode && !cs_sync_q[1];
  assign sck_rise = sck_sync_q[1] && !sck_prev_q;
  assign sck_fall = !sck_sync_q[1] && sck_prev_q;
  assign frame_start = frame && cs_prev_q;
  assign frame_end = cs_sync_q[1] && !cs_prev_q;
  assign word_done = (state_q == ST_DONE);
  assign is_read = shift_q[15];
  assign word_addr = shift_q[14:8];
  assign word_data = shift_q[7:0];

  // Frame sequencer: idle until chip select falls, shift 16 bits, then hold.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (!frame) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (frame_start) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (sck_rise && bit_cnt_q == WORD_BITS_5 - 5'h01) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
      endcase
    end
  end

  // Shift register samples data-in on rising serial clock edges, MSB first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end else if (state_q == ST_IDLE) begin
      bit_cnt_q <= 5'h00;
    end else if (state_q == ST_SHIFT && sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      shift_q <= {shift_q[14:0], sdi_sync_q[1]};
    end
  end

  // Register updates happen once, on the edge the sixteenth bit lands.
  logic commit;
  assign commit = frame && state_q == ST_SHIFT && sck_rise && bit_cnt_q == WORD_BITS_5 - 5'h01;
  logic [15:0] word_next;
  assign word_next = {shift_q[14:0], sdi_sync_q[1]};
  logic wr_cmd;
  assign wr_cmd = commit && !word_next[15];
  logic soft_reset;
  assign soft_reset = wr_cmd && word_next[14:8] == ADDR_SOFT_RESET
    && word_next[SOFT_RESET_BIT];

  // The reset bit has no storage, so it reads as zero once the write ends.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_reg_q <= REG_RESET_VALUE;
      timing_reg_q <= REG_RESET_VALUE;
      outmode_reg_q <= REG_RESET_VALUE;
    end else if (soft_reset) begin
      pd_reg_q <= REG_RESET_VALUE;
      timing_reg_q <= REG_RESET_VALUE;
      outmode_reg_q <= REG_RESET_VALUE;
    end else if (wr_cmd) begin
      if (word_next[14:8] == ADDR_POWER_DOWN) begin
        pd_reg_q <= word_next[7:0];
      end
      if (word_next[14:8] == ADDR_CLK_TIMING) begin
        timing_reg_q <= word_next[7:0];
      end
      if (word_next[14:8] == ADDR_OUT_MODE) begin
        outmode_reg_q <= word_next[7:0];
      end
    end
  end

  // Read mux; the write-only reset register and unmapped addresses read zero.
  always_comb begin
    read_mux = 8'h00;
    if (shift_q[6:0] == ADDR_POWER_DOWN) begin
      read_mux = pd_reg_q;
    end else if (shift_q[6:0] == ADDR_CLK_TIMING) begin
      read_mux = timing_reg_q;
    end else if (shift_q[6:0] == ADDR_OUT_MODE) begin
      read_mux = outmode_reg_q;
    end
  end

  // Read data is captured once the address is complete, then shifted on falling edges.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_byte_q <= 8'h00;
    end else if (state_q == ST_SHIFT && sck_rise && bit_cnt_q == DATA_START_5 - 5'h01) begin
      read_byte_q <= 8'h00; // Cleared so no stale byte from an earlier read shows.
    end else if (frame && sck_fall && bit_cnt_q > DATA_START_5 && bit_cnt_q < WORD_BITS_5) begin
      read_byte_q <= {read_byte_q[6:0], 1'b0};
    end else if (frame && bit_cnt_q == DATA_START_5 && sck_rise == 1'b0
                 && sck_fall == 1'b0 && shift_q[7]) begin
      read_byte_q <= read_mux;
    end
  end

  // Open drain: drive low only for a zero data bit of a read command.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_oe <= 1'b0;
      sdo_out <= 1'b0;
    end else begin
      sdo_out <= 1'b0;
      sdo_oe <= frame && state_q == ST_SHIFT && bit_cnt_q >= DATA_START_5
        && rd_flag_q && !read_byte_q[7];
    end
  end

  // The read flag is the first bit of the word; latched when the address completes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_flag_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      rd_flag_q <= 1'b0;
    end else if (state_q == ST_SHIFT && sck_rise && bit_cnt_q == DATA_START_5 - 5'h01) begin
      rd_flag_q <= shift_q[6];
    end
  end

  // Decode either the strap pins or the registers into the core controls.
  always_comb begin
    ctrl_d = '0;
    if (par_mode) begin
      ctrl_d.duty_stabilizer_enable = cs_sync_q[1];
      ctrl_d.output_format_select = sck_sync_q[1] ? FMT_LVDS_DDR : FMT_CMOS_FULL;
      ctrl_d.lvds_drive_current = LVDS_3P5MA;
      ctrl_d.lvds_termination_enable = 1'b0;
      ctrl_d.power_down_code = sdi_sync_q[1] ? PD_SLEEP : PD_NORMAL;
    end else begin
      ctrl_d.power_down_code = pd_reg_q[1:0];
      ctrl_d.out_clock_invert = timing_reg_q[3];
      ctrl_d.out_clock_phase = timing_reg_q[2:1];
      ctrl_d.duty_stabilizer_enable = timing_reg_q[0];
      ctrl_d.lvds_drive_current = outmode_reg_q[6:4];
      ctrl_d.lvds_termination_enable = outmode_reg_q[3];
      ctrl_d.output_disable = outmode_reg_q[2];
      ctrl_d.output_format_select = outmode_reg_q[1:0];
    end
  end

  // Registered so the core sees glitch-free controls.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl <= ctrl_d;
    end
  end

  sequence s_write_commit;
    wr_cmd && word_next[14:8] == ADDR_CLK_TIMING;
  endsequence

  chk_timing_write: assert property (@(posedge clk) disable iff (!rst_n)
    s_write_commit |=> timing_reg_q == $past(word_next[7:0]))
    else $error("timing register missed a write");
  chk_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset |=> pd_reg_q == 8'h00 && timing_reg_q == 8'h00 && outmode_reg_q == 8'h00)
    else $error("software reset did not clear registers");
  chk_read_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    commit && word_next[15] |=> $stable(timing_reg_q) && $stable(outmode_reg_q))
    else $error("read changed a register");
  chk_extra_edges: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_DONE && sck_rise |=> $stable(shift_q))
    else $error("bit after sixteenth was sampled");
  chk_par_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    par_mode && sdi_sync_q[1] |=> ctrl.power_down_code == PD_SLEEP)
    else $error("parallel sleep not applied");
  chk_par_dcs: assert property (@(posedge clk) disable iff (!rst_n)
    par_mode |=> ctrl.duty_stabilizer_enable == $past(cs_sync_q[1]))
    else $error("parallel stabilizer mismatch");
  chk_par_format: assert property (@(posedge clk) disable iff (!rst_n)
    par_mode && sck_sync_q[1] |=> ctrl.output_format_select == FMT_LVDS_DDR
    && ctrl.lvds_drive_current == LVDS_3P5MA && !ctrl.lvds_termination_enable)
    else $error("parallel LVDS mode wrong");
  chk_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
    sdo_out == 1'b0)
    else $error("data-out drove high");
  chk_oe_read: assert property (@(posedge clk) disable iff (!rst_n)
    sdo_oe |-> $past(rd_flag_q))
    else $error("data-out pulled low outside a read");
  chk_serial_map: assert property (@(posedge clk) disable iff (!rst_n)
    !par_mode |=> ctrl.output_format_select == $past(outmode_reg_q[1:0]))
    else $error("output format not from register");

  // Read commands: the whole word is kept and the registers stay put.
  sequence s_read_word;
    commit && word_next[15];
  endsequence

  chk_word_done: assert property (@(posedge clk) disable iff (!rst_n)
    commit |=> word_done && word_addr == $past(word_next[14:8]))
    else $error("word did not complete");
  chk_bit_count: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_SHIFT |-> bit_cnt_q < WORD_BITS_5)
    else $error("bit count passed the word length");
  chk_frame_close: assert property (@(posedge clk) disable iff (!rst_n)
    frame_end |=> state_q == ST_IDLE)
    else $error("frame did not close on chip select high");
  chk_pd_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cmd && word_next[14:8] == ADDR_POWER_DOWN |=> pd_reg_q == word_data)
    else $error("power-down register missed a write");
  chk_read_flag: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_word |=> is_read && $stable(pd_reg_q))
    else $error("read word changed the power-down register");
  chk_reset_reads: assert property (@(posedge clk) disable iff (!rst_n)
    frame && bit_cnt_q == DATA_START_5 && shift_q[7] && shift_q[6:0] == ADDR_SOFT_RESET
    && !sck_rise && !sck_fall |=> read_byte_q == 8'h00)
    else $error("reset register did not read zero");
  chk_oe_window: assert property (@(posedge clk) disable iff (!rst_n)
    sdo_oe |-> $past(bit_cnt_q) >= DATA_START_5 && $past(state_q) == ST_SHIFT)
    else $error("data-out pulled low outside the data bits");
  chk_oe_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !frame |=> !sdo_oe)
    else $error("data-out pulled low outside a frame");
  chk_par_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    par_mode |=> !ctrl.output_disable && !ctrl.out_clock_invert
    && ctrl.out_clock_phase == 2'h0)
    else $error("parallel mode took a register value");
  chk_ser_power: assert property (@(posedge clk) disable iff (!rst_n)
    !par_mode |=> ctrl.power_down_code == $past(pd_reg_q[1:0]))
    else $error("power-down code not from register");
  chk_ser_clock: assert property (@(posedge clk) disable iff (!rst_n)
    !par_mode |=> ctrl.out_clock_invert == $past(timing_reg_q[3])
    && ctrl.out_clock_phase == $past(timing_reg_q[2:1])
    && ctrl.duty_stabilizer_enable == $past(timing_reg_q[0]))
    else $error("clock controls not from register");
  chk_ser_lvds: assert property (@(posedge clk) disable iff (!rst_n)
    !par_mode |=> ctrl.lvds_drive_current == $past(outmode_reg_q[6:4])
    && ctrl.lvds_termination_enable == $past(outmode_reg_q[3]))
    else $error("drive controls not from register");
  chk_ser_disable: assert property (@(posedge clk) disable iff (!rst_n)
    !par_mode |=> ctrl.output_disable == $past(outmode_reg_q[2]))
    else $error("output disable not from register");
endmodule : amc_config_port

// ---- include/amc_pkg.sv ----
// Package for the converter mode configuration port: register map, fields, codes.
// Assumes a single 100 MHz system clock samples all serial port pins.
package amc_pkg;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
  localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
  localparam logic [6:0] ADDR_CLK_TIMING = 7'h02;
  localparam logic [6:0] ADDR_OUT_MODE = 7'h03;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam int SOFT_RESET_BIT = 7;
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam logic [4:0] WORD_BITS_5 = 5'h10;
  localparam logic [4:0] DATA_START_5 = 5'h08;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_NAP = 2'h1;
  localparam logic [1:0] PD_SLEEP = 2'h3;
  localparam logic [1:0] FMT_CMOS_FULL = 2'h0;
  localparam logic [1:0] FMT_LVDS_DDR = 2'h1;
  localparam logic [1:0] FMT_CMOS_DDR = 2'h2;
  localparam logic [2:0] LVDS_3P5MA = 3'h0;

  // Decoded operating controls handed to the converter core.
  typedef struct packed {
    logic [1:0] power_down_code;
    logic out_clock_invert;
    logic [1:0] out_clock_phase;
    logic duty_stabilizer_enable;
    logic [2:0] lvds_drive_current;
    logic lvds_termination_enable;
    logic output_disable;
    logic [1:0] output_format_select;
  } amc_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } amc_state_t;
endpackage : amc_pkg
